// [inc/mtu_defs.svh]
// register offsets, field positions and reset values of the timer unit
`ifndef MTU_DEFS_SVH
`define MTU_DEFS_SVH
`define MTU_ADDR_ANALOG_POWER_DOWN 8'h2D
`define MTU_ADDR_TIMER_CONTROL 8'h88
`define MTU_ADDR_TIMER_MODE_SELECT 8'h89
`define MTU_ADDR_T0L 8'h8A
`define MTU_ADDR_T1L 8'h8B
`define MTU_ADDR_T0H 8'h8C
`define MTU_ADDR_T1H 8'h8D
`define MTU_ADDR_ST_CFG 8'h93
`define MTU_ADDR_ST_SETH 8'h94
`define MTU_ADDR_ST_SETL 8'h95
`define MTU_RST_ANALOG_POWER_DOWN 8'hFF
`define MTU_RST_TIMER_CONTROL 8'h05
`define MTU_TIMER_CONTROL_TF1 7
`define MTU_TIMER_CONTROL_TR1 6
`define MTU_TIMER_CONTROL_TF0 5
`define MTU_TIMER_CONTROL_TR0 4
`define MTU_TIMER_CONTROL_IE1 3
`define MTU_TIMER_CONTROL_IE0 1
`define MTU_TIMER_CONTROL_RSV_MASK 8'h05
`define MTU_TIMER_MODE_SELECT_MASK 8'h33
`define MTU_CFG_EN 0
`define MTU_CFG_RLD 1
`define MTU_CFG_CLK 2
`define MTU_CFG_STEP 3
`define MTU_CFG_MASK 8'h0F
`define MTU_PRESCALE 12
`define MTU_STEP_LEN 65536
`endif

// [inc/mtu_pkg.sv]
// types shared by the timer unit modules
package mtu_pkg;
   typedef enum logic [1:0] {
      MTU_M13 = 2'b00,
      MTU_M16 = 2'b01,
      MTU_M8R = 2'b10,
      MTU_MSPLIT = 2'b11
   } mtu_mode_type;
endpackage : mtu_pkg

// [inc/mtu_tick_if.sv]
// tick event carried from the top to the classic timer cores
`timescale 1ns/100ps
interface mtu_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface : mtu_tick_if

// [rtl/mtu_classic_core.sv]
// one classic timer: count step for modes 0 to 2
`timescale 1ns/100ps
module mtu_classic_core (
   mtu_tick_if.dst tk,
   input wire logic run,
   input wire logic [1:0] mode,
   input wire logic [7:0] lo,
   input wire logic [7:0] hi,
   output logic [7:0] lo_nxt,
   output logic [7:0] hi_nxt,
   output logic ovf
);
   always_comb begin
      lo_nxt = lo;
      hi_nxt = hi;
      ovf = 1'b0;
      if (tk.tick && run) begin
         case (mode)
            mtu_pkg::MTU_M13: begin
               // low-part wrap carries into the high byte
               lo_nxt = {lo[7:5], lo[4:0] + 5'h01};
               if (lo[4:0] == 5'h1F) begin
                  hi_nxt = hi + 8'h01;
                  ovf = (hi == 8'hFF);
               end
            end
            mtu_pkg::MTU_M16: begin
               lo_nxt = lo + 8'h01;
               if (lo == 8'hFF) begin
                  hi_nxt = hi + 8'h01;
                  ovf = (hi == 8'hFF);
               end
            end
            mtu_pkg::MTU_M8R: begin
               lo_nxt = (lo == 8'hFF) ? hi : lo + 8'h01;
               ovf = (lo == 8'hFF);
            end
            default: begin
               // split mode is handled by the caller
               lo_nxt = lo;
            end
         endcase
      end
   end
endmodule : mtu_classic_core

// [rtl/mtu_slow_timer.sv]
// slow timer: 32-bit count on a 32 kHz source, set value, step, reload
`timescale 1ns/100ps
`include "mtu_defs.svh"
module mtu_slow_timer #(
   parameter int STEP_LEN = `MTU_STEP_LEN
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic src_tick,
   input wire logic enable,
   input wire logic step_mode,
   input wire logic [15:0] set_value,
   input wire logic restart,
   output logic done
);
   logic [31:0] cnt_r;
   logic [31:0] target;
   always_comb begin
      if (step_mode)
         target = ({16'h0000, set_value} + 32'h0000_0001) * 32'(STEP_LEN);
      else
         target = {16'h0000, set_value} + 32'h0000_0001;
   end
   assign done = enable && src_tick && (cnt_r + 32'h0000_0001 == target);
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         cnt_r <= 32'h0000_0000;
      else if (restart || done)
         cnt_r <= 32'h0000_0000;
      else if (enable && src_tick)
         cnt_r <= cnt_r + 32'h0000_0001;
   end
   property p_period_reset;
      @(posedge clock) disable iff (rst) done |=> cnt_r == 32'h0;
   endproperty
   a_period_reset: assert property (p_period_reset) else
      $error("count not cleared at period end");
endmodule : mtu_slow_timer

// [rtl/mtu_timer_unit.sv]
// timer unit: two classic timers and the slow 32 kHz timer
`timescale 1ns/100ps
`include "mtu_defs.svh"
// How it works
// - classic timers step on system clock divided by twelve
// - timer 1 mode in bits 5:4, timer 0 mode in bits 1:0
// - 13-bit mode uses high byte and low five bits of low byte
// - 13-bit wrap goes to zero and sets overflow flag
// - 16-bit mode concatenates bytes, wraps past FFFF setting flag
// - 8-bit reload mode reloads low byte from high byte past FF
// - a classic timer counts only while its run bit is one, except timer 1 during split, which counts regardless
// - timer 1 in mode 3 holds its count
// - split mode: low byte uses timer 0 bits, high byte timer 1 bits
// - during split, timer 1 counts in modes 0-2 but sets no flag
// - flag bit 7 for timer 1 or split high byte, bit 5 for timer 0
// - bit 4 runs timer 0, bit 6 runs timer 1 or split high byte
// - external interrupt flags bits 3 and 1 set by hardware
// - slow timer 32-bit counter interrupts on reaching set value
// - slow period is source period times set value plus one
// - writing config or set bytes clears slow counter
// - slow interrupt wakes from idle, software clears the flag
// - config bits: 0 enable, 1 reload, 2 clock select, 3 step
// - clock select one picks crystal, zero picks low-speed RC
// - single mode clears enable when a period completes
// - step mode makes each step last 65536 source clocks
module mtu_timer_unit #(
   parameter int PRESCALE = `MTU_PRESCALE,
   parameter int STEP_LEN = `MTU_STEP_LEN
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic ext_irq_a_event,
   input wire logic ext_irq_b_event,
   input wire logic low_speed_rc_clock_tick,
   input wire logic crystal_clock_tick,
   input wire logic idle_mode,
   input wire logic slow_flag_clr,
   output logic slow_timer_irq,
   output logic wake_up,
   output logic first_timer_overflow_irq,
   output logic second_timer_overflow_irq
);
   // ******************************************************
   // register state
   // ******************************************************
   logic [7:0] timer_control_r;
   logic [7:0] timer_mode_select_r;
   logic [7:0] t0l_r;
   logic [7:0] t0h_r;
   logic [7:0] t1l_r;
   logic [7:0] t1h_r;
   logic [7:0] cfg_r;
   logic [7:0] seth_r;
   logic [7:0] setl_r;
   logic [7:0] analog_power_down_r;
   logic slow_flag_r;
   logic [3:0] pre_r;
   logic [3:0] gap_r;
   logic tick;
   logic wr_timer_control;
   logic wr_timer_mode_select;
   logic wr_t0l;
   logic wr_t0h;
   logic wr_t1l;
   logic wr_t1h;
   logic wr_cfg;
   logic wr_seth;
   logic wr_setl;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic split;
   logic [7:0] c0_lo_nxt;
   logic [7:0] c0_hi_nxt;
   logic c0_ovf;
   logic [7:0] c1_lo_nxt;
   logic [7:0] c1_hi_nxt;
   logic c1_ovf;
   logic [7:0] t0l_nxt;
   logic [7:0] t0h_nxt;
   logic t0_ovf;
   logic th0_ovf;
   logic t1_run;
   logic set_tf0;
   logic set_tf1;
   logic slow_src;
   logic slow_done;
   logic slow_restart;

   assign wr_timer_control = sfr_wr && (sfr_addr == `MTU_ADDR_TIMER_CONTROL);
   assign wr_timer_mode_select = sfr_wr && (sfr_addr == `MTU_ADDR_TIMER_MODE_SELECT);
   assign wr_t0l = sfr_wr && (sfr_addr == `MTU_ADDR_T0L);
   assign wr_t0h = sfr_wr && (sfr_addr == `MTU_ADDR_T0H);
   assign wr_t1l = sfr_wr && (sfr_addr == `MTU_ADDR_T1L);
   assign wr_t1h = sfr_wr && (sfr_addr == `MTU_ADDR_T1H);
   assign wr_cfg = sfr_wr && (sfr_addr == `MTU_ADDR_ST_CFG);
   assign wr_seth = sfr_wr && (sfr_addr == `MTU_ADDR_ST_SETH);
   assign wr_setl = sfr_wr && (sfr_addr == `MTU_ADDR_ST_SETL);

   // ******************************************************
   // divide-by-twelve prescaler
   // ******************************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         pre_r <= 4'h0;
      else if (pre_r == 4'(PRESCALE - 1))
         pre_r <= 4'h0;
      else
         pre_r <= pre_r + 4'h1;
   end
   // one tick per twelve system clocks, in every mode
   assign tick = (pre_r == 4'(PRESCALE - 1));

   mtu_tick_if tick_bus ();
   assign tick_bus.tick = tick;

   // ******************************************************
   // classic timers
   // ******************************************************
   assign mode0 = timer_mode_select_r[1:0];
   assign mode1 = timer_mode_select_r[5:4];
   assign split = (mode0 == 2'b11);
   // mode 3 on timer 1 halts it; in split, its run bit is borrowed
   assign t1_run = (mode1 != 2'b11) &&
                   (split || timer_control_r[`MTU_TIMER_CONTROL_TR1]);

   mtu_classic_core u_core0 (
      .tk(tick_bus.dst),
      .run(timer_control_r[`MTU_TIMER_CONTROL_TR0]),
      .mode(mode0),
      .lo(t0l_r),
      .hi(t0h_r),
      .lo_nxt(c0_lo_nxt),
      .hi_nxt(c0_hi_nxt),
      .ovf(c0_ovf)
   );
   mtu_classic_core u_core1 (
      .tk(tick_bus.dst),
      .run(t1_run),
      .mode(mode1),
      .lo(t1l_r),
      .hi(t1h_r),
      .lo_nxt(c1_lo_nxt),
      .hi_nxt(c1_hi_nxt),
      .ovf(c1_ovf)
   );

   always_comb begin
      t0l_nxt = c0_lo_nxt;
      t0h_nxt = c0_hi_nxt;
      t0_ovf = c0_ovf;
      th0_ovf = 1'b0;
      if (split) begin
         // two independent 8-bit timers
         t0l_nxt = t0l_r;
         t0h_nxt = t0h_r;
         t0_ovf = 1'b0;
         if (tick && timer_control_r[`MTU_TIMER_CONTROL_TR0]) begin
            t0l_nxt = t0l_r + 8'h01;
            t0_ovf = (t0l_r == 8'hFF);
         end
         if (tick && timer_control_r[`MTU_TIMER_CONTROL_TR1]) begin
            t0h_nxt = t0h_r + 8'h01;
            th0_ovf = (t0h_r == 8'hFF);
         end
      end
   end

   assign set_tf0 = t0_ovf;
   // timer 1 loses its flag while timer 0 is split
   assign set_tf1 = split ? th0_ovf : c1_ovf;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         t0l_r <= 8'h00;
         t0h_r <= 8'h00;
      end else begin
         t0l_r <= wr_t0l ? sfr_wdata : t0l_nxt;
         t0h_r <= wr_t0h ? sfr_wdata : t0h_nxt;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         t1l_r <= 8'h00;
         t1h_r <= 8'h00;
      end else begin
         t1l_r <= wr_t1l ? sfr_wdata : c1_lo_nxt;
         t1h_r <= wr_t1h ? sfr_wdata : c1_hi_nxt;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         timer_mode_select_r <= 8'h00;
      else if (wr_timer_mode_select)
         timer_mode_select_r <= sfr_wdata & `MTU_TIMER_MODE_SELECT_MASK;
   end

   // hardware sets win over a software write in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         timer_control_r <= `MTU_RST_TIMER_CONTROL;
      else begin
         if (wr_timer_control)
            timer_control_r <= (sfr_wdata & ~`MTU_TIMER_CONTROL_RSV_MASK) |
                      (timer_control_r & `MTU_TIMER_CONTROL_RSV_MASK);
         if (set_tf1)
            timer_control_r[`MTU_TIMER_CONTROL_TF1] <= 1'b1;
         if (set_tf0)
            timer_control_r[`MTU_TIMER_CONTROL_TF0] <= 1'b1;
         if (ext_irq_b_event)
            timer_control_r[`MTU_TIMER_CONTROL_IE1] <= 1'b1;
         if (ext_irq_a_event)
            timer_control_r[`MTU_TIMER_CONTROL_IE0] <= 1'b1;
      end
   end

   assign first_timer_overflow_irq = timer_control_r[`MTU_TIMER_CONTROL_TF0];
   assign second_timer_overflow_irq = timer_control_r[`MTU_TIMER_CONTROL_TF1];

   // ******************************************************
   // slow timer
   // ******************************************************
   assign slow_src = cfg_r[`MTU_CFG_CLK] ? crystal_clock_tick
                                        : low_speed_rc_clock_tick;
   assign slow_restart = wr_cfg || wr_seth || wr_setl;

   mtu_slow_timer #(.STEP_LEN(STEP_LEN)) u_slow (
      .clock(clock),
      .rst(rst),
      .src_tick(slow_src),
      .enable(cfg_r[`MTU_CFG_EN]),
      .step_mode(cfg_r[`MTU_CFG_STEP]),
      .set_value({seth_r, setl_r}),
      .restart(slow_restart),
      .done(slow_done)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         cfg_r <= 8'h00;
      else if (wr_cfg)
         cfg_r <= sfr_wdata & `MTU_CFG_MASK;
      else if (slow_done && !cfg_r[`MTU_CFG_RLD])
         cfg_r[`MTU_CFG_EN] <= 1'b0;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         seth_r <= 8'h00;
         setl_r <= 8'h00;
      end else begin
         if (wr_seth)
            seth_r <= sfr_wdata;
         if (wr_setl)
            setl_r <= sfr_wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         analog_power_down_r <= `MTU_RST_ANALOG_POWER_DOWN;
      else if (sfr_wr && sfr_addr == `MTU_ADDR_ANALOG_POWER_DOWN)
         analog_power_down_r <= sfr_wdata;
   end

   // flag cleared by a pulse on the clear strobe input;
   // a completion in the same cycle wins
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         slow_flag_r <= 1'b0;
      else if (slow_done)
         slow_flag_r <= 1'b1;
      else if (slow_flag_clr)
         slow_flag_r <= 1'b0;
   end

   assign slow_timer_irq = slow_flag_r;
   assign wake_up = idle_mode && slow_flag_r;

   // ******************************************************
   // read path
   // ******************************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         sfr_rdata <= 8'h00;
      else if (sfr_rd) begin
         case (sfr_addr)
            `MTU_ADDR_TIMER_CONTROL: sfr_rdata <= timer_control_r;
            `MTU_ADDR_TIMER_MODE_SELECT: sfr_rdata <= timer_mode_select_r;
            `MTU_ADDR_T0L: sfr_rdata <= t0l_r;
            `MTU_ADDR_T1L: sfr_rdata <= t1l_r;
            `MTU_ADDR_T0H: sfr_rdata <= t0h_r;
            `MTU_ADDR_T1H: sfr_rdata <= t1h_r;
            `MTU_ADDR_ST_CFG: sfr_rdata <= cfg_r;
            `MTU_ADDR_ST_SETH: sfr_rdata <= seth_r;
            `MTU_ADDR_ST_SETL: sfr_rdata <= setl_r;
            `MTU_ADDR_ANALOG_POWER_DOWN: sfr_rdata <= analog_power_down_r;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ******************************************************
   // checks
   // ******************************************************
   // cycles since the last tick, kept apart from the prescaler
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         gap_r <= 4'h0;
      else
         gap_r <= tick ? 4'h0 : gap_r + 4'h1;
   end
   property p_tick_spacing;
      @(posedge clock) disable iff (rst) tick == (gap_r == 4'(PRESCALE - 1));
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else
      $error("prescaler tick not every twelve clocks");
   property p_t0_stop;
      @(posedge clock) disable iff (rst)
         !timer_control_r[`MTU_TIMER_CONTROL_TR0] && !wr_t0l |=> t0l_r == $past(t0l_r);
   endproperty
   a_t0_stop: assert property (p_t0_stop) else
      $error("timer 0 low byte moved while stopped");
   property p_t1_hold;
      @(posedge clock) disable iff (rst)
         mode1 == 2'b11 && !wr_t1l && !wr_t1h |=>
         t1l_r == $past(t1l_r) && t1h_r == $past(t1h_r);
   endproperty
   a_t1_hold: assert property (p_t1_hold) else
      $error("timer 1 moved in mode 3");
   property p_reload;
      @(posedge clock) disable iff (rst)
         mode0 == 2'b10 && tick && timer_control_r[`MTU_TIMER_CONTROL_TR0] &&
         t0l_r == 8'hFF && !wr_t0l && !wr_t0h |=> t0l_r == $past(t0h_r);
   endproperty
   a_reload: assert property (p_reload) else
      $error("auto reload did not copy high byte");
   property p_tf0_set;
      @(posedge clock) disable iff (rst)
         set_tf0 |=> timer_control_r[`MTU_TIMER_CONTROL_TF0];
   endproperty
   a_tf0_set: assert property (p_tf0_set) else
      $error("timer 0 overflow flag not set");
   property p_ie1_set;
      @(posedge clock) disable iff (rst)
         ext_irq_b_event |=> timer_control_r[`MTU_TIMER_CONTROL_IE1];
   endproperty
   a_ie1_set: assert property (p_ie1_set) else
      $error("external flag b not set");
   property p_single_stop;
      @(posedge clock) disable iff (rst)
         slow_done && !cfg_r[`MTU_CFG_RLD] && !wr_cfg |=>
         !cfg_r[`MTU_CFG_EN] && slow_flag_r;
   endproperty
   a_single_stop: assert property (p_single_stop) else
      $error("single mode did not stop");
   property p_split_flag;
      @(posedge clock) disable iff (rst)
         split && !th0_ovf && !wr_timer_control |=>
         timer_control_r[`MTU_TIMER_CONTROL_TF1] == $past(timer_control_r[`MTU_TIMER_CONTROL_TF1]);
   endproperty
   a_split_flag: assert property (p_split_flag) else
      $error("timer 1 set its flag during split");
endmodule : mtu_timer_unit

// [test/mtu_timer_unit_bench.sv]
// self-checking testbench of the timer unit, driven through its registers
`timescale 1ns/100ps
`include "mtu_defs.svh"
module mtu_timer_unit_bench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic ext_irq_a_event = 1'b0;
   logic ext_irq_b_event = 1'b0;
   logic low_speed_rc_clock_tick = 1'b0;
   logic crystal_clock_tick = 1'b0;
   logic idle_mode = 1'b0;
   logic slow_flag_clr = 1'b0;
   logic [7:0] sfr_rdata;
   logic slow_timer_irq;
   logic wake_up;
   logic first_timer_overflow_irq;
   logic second_timer_overflow_irq;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] ra [11] = '{8'h2D, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D,
      8'h93, 8'h94, 8'h95, 8'h00};
   logic [7:0] re [11] = '{8'hFF, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};

   always #20 clock = ~clock;

   // step length cut down so the step mode finishes in a few source ticks
   mtu_timer_unit #(.PRESCALE(12), .STEP_LEN(4)) mtu_timer_unit_i (
      .clock(clock),
      .rst(rst),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .ext_irq_a_event(ext_irq_a_event),
      .ext_irq_b_event(ext_irq_b_event),
      .low_speed_rc_clock_tick(low_speed_rc_clock_tick),
      .crystal_clock_tick(crystal_clock_tick),
      .idle_mode(idle_mode),
      .slow_flag_clr(slow_flag_clr),
      .slow_timer_irq(slow_timer_irq),
      .wake_up(wake_up),
      .first_timer_overflow_irq(first_timer_overflow_irq),
      .second_timer_overflow_irq(second_timer_overflow_irq)
   );

   // ************************************************************
   // access tasks and comparison
   // ************************************************************
   task final_report;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : wr

   // an extra edge before sampling: read data stands until the next read
   task rd_chk(input logic [7:0] a, input logic [7:0] e,
         input logic [7:0] m = 8'hFF);
      @(posedge clock);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      @(posedge clock);
      #1;
      chk(sfr_rdata & m, e);
   endtask : rd_chk

   task do_reset;
      @(posedge clock);
      rst <= 1'b1;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
   endtask : do_reset

   // load a classic timer, run it until its flag rises, stop, read back
   task run_t(input logic [7:0] md, input logic [7:0] run,
         input logic [7:0] a_hi, input logic [7:0] a_lo,
         input logic [7:0] th, input logic [7:0] tl,
         input logic [7:0] eh, input logic [7:0] el,
         input logic [7:0] m, input logic t);
      int n;
      n = 0;
      wr(`MTU_ADDR_TIMER_CONTROL, 8'h00);
      wr(`MTU_ADDR_TIMER_MODE_SELECT, md);
      wr(a_hi, th);
      wr(a_lo, tl);
      wr(`MTU_ADDR_TIMER_CONTROL, run);
      while (n < 60 && (t ? second_timer_overflow_irq
            : first_timer_overflow_irq) !== 1'b1) begin
         @(posedge clock);
         n++;
      end
      chk({7'h00, t ? second_timer_overflow_irq : first_timer_overflow_irq},
         8'h01);
      chk(8'(n > 10), 8'h01);
      wr(`MTU_ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(a_hi, eh);
      rd_chk(a_lo, el, m);
   endtask : run_t

   // pulse the chosen 32 kHz source once, then the other for two cycles,
   // so a wrong source select shows up as an early completion
   task src(input int n, input logic xt);
      repeat (n) begin
         @(posedge clock);
         low_speed_rc_clock_tick <= !xt;
         crystal_clock_tick <= xt;
         @(posedge clock);
         low_speed_rc_clock_tick <= xt;
         crystal_clock_tick <= !xt;
         repeat (2) @(posedge clock);
         low_speed_rc_clock_tick <= 1'b0;
         crystal_clock_tick <= 1'b0;
      end
      repeat (3) @(posedge clock);
      #1;
   endtask : src

   // a hang ends in the closing report, counted as a mismatch
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report;
      end
   end

   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         rd_chk(ra[i], re[i]);
      end
      wr(`MTU_ADDR_TIMER_MODE_SELECT, 8'hFF);
      rd_chk(`MTU_ADDR_TIMER_MODE_SELECT, 8'h33);
      @(posedge clock);
      ext_irq_a_event <= 1'b1;
      @(posedge clock);
      ext_irq_a_event <= 1'b0;
      rd_chk(`MTU_ADDR_TIMER_CONTROL, 8'h07);
      @(posedge clock);
      ext_irq_b_event <= 1'b1;
      @(posedge clock);
      ext_irq_b_event <= 1'b0;
      rd_chk(`MTU_ADDR_TIMER_CONTROL, 8'h0F);
      wr(`MTU_ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(`MTU_ADDR_TIMER_CONTROL, 8'h05);
      run_t(8'h01, 8'h10, `MTU_ADDR_T0H, `MTU_ADDR_T0L, 8'hFF, 8'hFE,
         8'h00, 8'h00, 8'hFF, 1'b0);
      run_t(8'h00, 8'h10, `MTU_ADDR_T0H, `MTU_ADDR_T0L, 8'hFF, 8'h3E,
         8'h00, 8'h00, 8'h1F, 1'b0);
      run_t(8'h02, 8'h10, `MTU_ADDR_T0H, `MTU_ADDR_T0L, 8'hA5, 8'hFE,
         8'hA5, 8'hA5, 8'hFF, 1'b0);
      run_t(8'h10, 8'h40, `MTU_ADDR_T1H, `MTU_ADDR_T1L, 8'hFF, 8'hFE,
         8'h00, 8'h00, 8'hFF, 1'b1);
      run_t(8'h00, 8'h40, `MTU_ADDR_T1H, `MTU_ADDR_T1L, 8'hFF, 8'h3E,
         8'h00, 8'h00, 8'h1F, 1'b1);
      run_t(8'h20, 8'h40, `MTU_ADDR_T1H, `MTU_ADDR_T1L, 8'h5A, 8'hFE,
         8'h5A, 8'h5A, 8'hFF, 1'b1);
      run_t(8'h03, 8'h10, `MTU_ADDR_T0H, `MTU_ADDR_T0L, 8'h00, 8'hFE,
         8'h00, 8'h00, 8'hFF, 1'b0);
      run_t(8'h03, 8'h40, `MTU_ADDR_T0H, `MTU_ADDR_T0L, 8'hFE, 8'h33,
         8'h00, 8'h33, 8'hFF, 1'b1);
      wr(`MTU_ADDR_TIMER_MODE_SELECT, 8'h30);
      wr(`MTU_ADDR_T1H, 8'h12);
      wr(`MTU_ADDR_T1L, 8'h34);
      wr(`MTU_ADDR_TIMER_CONTROL, 8'h40);
      repeat (40) @(posedge clock);
      chk({7'h00, second_timer_overflow_irq}, 8'h00);
      rd_chk(`MTU_ADDR_T1H, 8'h12);
      rd_chk(`MTU_ADDR_T1L, 8'h34);
      rd_chk(`MTU_ADDR_T0L, 8'h33);
      // a mid-run reset starts the slow timer runs from a clean state
      do_reset;
      wr(`MTU_ADDR_ST_SETH, 8'h00);
      wr(`MTU_ADDR_ST_SETL, 8'h03);
      wr(`MTU_ADDR_ST_CFG, 8'h01);
      src(2, 1'b0);
      wr(`MTU_ADDR_ST_SETL, 8'h03);
      src(3, 1'b0);
      chk({7'h00, slow_timer_irq}, 8'h00);
      src(1, 1'b0);
      chk({7'h00, slow_timer_irq}, 8'h01);
      chk({7'h00, wake_up}, 8'h00);
      @(posedge clock);
      idle_mode <= 1'b1;
      @(posedge clock);
      #1;
      chk({7'h00, wake_up}, 8'h01);
      @(posedge clock);
      idle_mode <= 1'b0;
      rd_chk(`MTU_ADDR_ST_CFG, 8'h00);
      do_reset;
      wr(`MTU_ADDR_ST_SETL, 8'h01);
      wr(`MTU_ADDR_ST_CFG, 8'h0F);
      src(7, 1'b1);
      chk({7'h00, slow_timer_irq}, 8'h00);
      src(1, 1'b1);
      chk({7'h00, slow_timer_irq}, 8'h01);
      rd_chk(`MTU_ADDR_ST_CFG, 8'h0F);
      @(posedge clock);
      slow_flag_clr <= 1'b1;
      @(posedge clock);
      slow_flag_clr <= 1'b0;
      #1;
      chk({7'h00, slow_timer_irq}, 8'h00);
      src(8, 1'b1);
      chk({7'h00, slow_timer_irq}, 8'h01);
      final_report;
   end
endmodule : mtu_timer_unit_bench
